// [src/hpp_dev_end.sv]
// Purpose: Device end of the host parallel port.
// Assumes: Pins arrive asynchronous to sys_clk.
// Notes:   Data reads fetch through a request/ack port, except narrow second halves; data writes fill a FIFO.
`timescale 1ns/1ps
module hpp_dev_end
  import hpp_pkg::*;
(
  // Clock and reset.
  input  wire logic              sys_clk,
  input  wire logic              rst,
  // Pin side.
  hpp_link_if.dev                link,
  // Mode strap, high selects 16-bit halves.
  input  wire logic              narrow_16bit_mode,
  // Fetch port toward the address generator.
  output logic                   fetch_req,
  output logic [CTL_W-1:0]       fetch_type,
  input  wire logic              fetch_ack,
  input  wire logic [DATA_W-1:0] fetch_data,
  // Drained write words.
  output logic                   wr_valid,
  input  wire logic              wr_ready,
  output logic      [DATA_W-1:0] wr_data,
  output logic      [CTL_W-1:0]  ctl_type
);

  // ---------------------------------------------------------------------
  // Pin synchronisers.
  // ---------------------------------------------------------------------
  localparam int unsigned PIN_N = DATA_W + CTL_W + 4;

  logic [PIN_N-1:0] pin_raw;
  logic [PIN_N-1:0] s1_q;
  logic [PIN_N-1:0] s2_q;
  logic [PIN_N-1:0] s3_q;
  logic [PIN_N-1:0] pin_q;
  logic             stb_raw_n;

  assign stb_raw_n = ~(link.data_strobe_one_n ^ link.data_strobe_two_n)
                     | link.host_select_n;
  assign pin_raw = {link.host_data_bus, link.access_type_sel,
                    link.read_not_write, link.halfword_select,
                    link.address_latch_strobe_n, stb_raw_n};

  // Three stages; a change is accepted once stages two and three agree.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s1_q  <= '1;
      s2_q  <= '1;
      s3_q  <= '1;
      pin_q <= '1;
    end else begin
      s1_q  <= pin_raw;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      pin_q <= (s2_q & s3_q) | (~(s2_q ^ s3_q) & s2_q) |
               ((s2_q ^ s3_q) & pin_q);
    end
  end

  // ---------------------------------------------------------------------
  // Edge detection and select capture.
  // ---------------------------------------------------------------------
  logic              stb_n;
  logic              stb_prev_q;
  logic              als_prev_q;
  logic              stb_fall;
  logic              stb_rise;
  logic              als_fall;
  logic [DATA_W-1:0] pin_data;
  logic [CTL_W+1:0]  pin_sel;
  logic [CTL_W+1:0]  lat_sel_q;
  logic              als_used_q;
  logic [CTL_W+1:0]  acc_sel;

  assign stb_n    = pin_q[0];
  assign pin_data = pin_q[PIN_N-1 -: DATA_W];
  assign pin_sel  = {pin_q[CTL_W+3:4], pin_q[3], pin_q[2]};
  assign stb_fall = stb_prev_q && !stb_n;
  assign stb_rise = !stb_prev_q && stb_n;
  assign als_fall = als_prev_q && !pin_q[1];
  // Latched selects when the latch strobe ran, live selects otherwise.
  assign acc_sel  = als_used_q ? lat_sel_q : pin_sel;

  // Edge history and latched selects.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      stb_prev_q <= 1'b1;
      als_prev_q <= 1'b1;
      lat_sel_q  <= '0;
      als_used_q <= 1'b0;
    end else begin
      stb_prev_q <= stb_n;
      als_prev_q <= pin_q[1];
      if (als_fall && stb_n) begin
        lat_sel_q  <= pin_sel;
        als_used_q <= 1'b1;
      end else if (stb_rise) begin
        als_used_q <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------------
  // Access decode.
  // ---------------------------------------------------------------------
  logic [CTL_W-1:0] typ;
  logic             is_rd;
  logic             is_half2;
  logic             is_data;

  assign typ      = acc_sel[CTL_W+1:2];
  assign is_rd    = acc_sel[1];
  // The half select only counts in narrow mode.
  assign is_half2 = narrow_16bit_mode &&
                    (acc_sel[0] != HALF_FIRST);
  assign is_data  = (typ == ACC_DATA) || (typ == ACC_DINC);

  // ---------------------------------------------------------------------
  // Write buffer.
  // ---------------------------------------------------------------------
  logic              fifo_in_valid;
  logic              fifo_in_ready;
  logic [DATA_W-1:0] wr_word;

  hpp_fifo #(
    .WIDTH (FIFO_W),
    .DEPTH (FIFO_D)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (wr_word),
    .out_valid (wr_valid),
    .out_ready (wr_ready),
    .out_data  (wr_data)
  );

  // ---------------------------------------------------------------------
  // Access sequencer.
  // ---------------------------------------------------------------------
  hpp_dev_state_t    st_q;
  hpp_dev_state_t    st_d;
  logic [DATA_W-1:0] hold_q;
  logic [HALF_W-1:0] low_half_q;
  logic              wait_n_q;
  logic              oe_q;
  logic              wr_half2_q;
  logic [CTL_W-1:0]  typ_q;
  logic              want_push;

  // Narrow first halves are parked; the second half completes the word.
  assign wr_word   = narrow_16bit_mode ?
                     {pin_data[HALF_W-1:0], low_half_q} : pin_data;
  assign want_push = stb_rise && (st_q == DS_WRITE) && is_data &&
                     (!narrow_16bit_mode || wr_half2_q);
  assign fifo_in_valid = want_push;

  // Next state.
  always_comb begin
    st_d = st_q;
    case (st_q)
      DS_IDLE: begin
        if (stb_fall && is_rd && is_data && !is_half2) begin
          st_d = DS_FETCH;
        end else if (stb_fall && is_rd) begin
          st_d = DS_DONE;
        end else if (stb_fall) begin
          st_d = DS_WRITE;
        end
      end
      DS_FETCH: if (fetch_ack) st_d = DS_DONE;
      DS_WRITE: if (stb_rise) st_d = DS_IDLE;
      DS_DONE:  if (stb_rise) st_d = DS_IDLE;
      default:  st_d = DS_IDLE;
    endcase
  end

  // Registered state, wait, drivers and read data.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_q       <= DS_IDLE;
      hold_q     <= '0;
      low_half_q <= '0;
      wait_n_q   <= 1'b0;
      oe_q       <= 1'b0;
      wr_half2_q <= 1'b0;
      typ_q      <= '0;
    end else begin
      st_q <= st_d;
      if (stb_fall) typ_q <= typ;
      if (fetch_ack && st_q == DS_FETCH) hold_q <= fetch_data;
      if (stb_rise && st_q == DS_WRITE) begin
        low_half_q <= pin_data[HALF_W-1:0];
        wr_half2_q <= narrow_16bit_mode && !is_half2 ? 1'b1 : 1'b0;
      end
      // High holds the host off; low lets it finish the access.
      wait_n_q <= (st_d == DS_FETCH) ||
                  (st_d == DS_WRITE && is_data && !fifo_in_ready);
      oe_q     <= is_rd && (st_d == DS_FETCH || st_d == DS_DONE)
                  && !stb_n;
    end
  end

  assign fetch_req  = (st_q == DS_FETCH);
  assign fetch_type = typ_q;
  assign ctl_type   = typ_q;

  // Narrow mode drives low half first, then the held high half.
  logic [DATA_W-1:0] half_lo;
  logic [DATA_W-1:0] half_hi;

  assign half_lo         = {{HALF_W{1'b0}}, hold_q[HALF_W-1:0]};
  assign half_hi         = {{HALF_W{1'b0}}, hold_q[DATA_W-1 -: HALF_W]};
  assign link.hd_dev_o   = !narrow_16bit_mode ? hold_q :
                           is_half2 ? half_hi : half_lo;
  assign link.hd_dev_oe  = oe_q;
  assign link.host_wait_n = wait_n_q;
endmodule

// [src/hpp_pkg.sv]
// Purpose: Shared constants and types for the host parallel port.
// Assumes: 200 MHz sys_clk on both ends.
// Notes:   Timing counts derive from the printed figures.
package hpp_pkg;

  // ---------------------------------------------------------------------
  // Widths and depths.
  // ---------------------------------------------------------------------
  localparam int unsigned DATA_W    = 32;
  localparam int unsigned HALF_W    = 16;
  localparam int unsigned FIFO_W    = 32;
  localparam int unsigned FIFO_D    = 16;
  localparam int unsigned CTL_W     = 2;
  localparam int unsigned SYNC_LEN  = 3;

  // ---------------------------------------------------------------------
  // Timing.
  // ---------------------------------------------------------------------
  localparam int unsigned CLK_PS        = 5000;
  localparam int unsigned STB_GAP_P     = 4;
  localparam int unsigned STB_LOW_PS    = 12500;
  localparam int unsigned HOLD_STB_CYC  = ((STB_LOW_PS + CLK_PS - 1) / CLK_PS)
                                          + SYNC_LEN;
  localparam int unsigned GAP_CYC       = STB_GAP_P + SYNC_LEN;
  localparam logic [3:0]  HOLD_STB_C    = 4'(HOLD_STB_CYC);
  localparam logic [3:0]  GAP_C         = 4'(GAP_CYC);

  // ---------------------------------------------------------------------
  // Access type codes and the half-select encoding.
  // ---------------------------------------------------------------------
  localparam logic [1:0] ACC_CTRL  = 2'h0;
  localparam logic [1:0] ACC_ADDR  = 2'h1;
  localparam logic [1:0] ACC_DINC  = 2'h2;
  localparam logic [1:0] ACC_DATA  = 2'h3;
  localparam logic       HALF_FIRST = 1'h0;

  // Device-end access sequencer states.
  typedef enum logic [3:0] {
    DS_IDLE  = 4'h1,
    DS_FETCH = 4'h2,
    DS_WRITE = 4'h4,
    DS_DONE  = 4'h8
  } hpp_dev_state_t;

  // Host-end access sequencer states.
  typedef enum logic [4:0] {
    HS_IDLE = 5'h01,
    HS_LAT  = 5'h02,
    HS_LOW  = 5'h04,
    HS_WAIT = 5'h08,
    HS_GAP  = 5'h10
  } hpp_host_state_t;

endpackage

// [src/hpp_link_if.sv]
// Purpose: Pin-level carrier between host end and device end.
// Assumes: The testbench or this interface resolves the data bus.
// Notes:   The bus level is worked out from the two output enables.
`timescale 1ns/1ps
interface hpp_link_if;
  import hpp_pkg::*;

  logic              host_select_n;
  logic              data_strobe_one_n;
  logic              data_strobe_two_n;
  logic              address_latch_strobe_n;
  logic [CTL_W-1:0]  access_type_sel;
  logic              read_not_write;
  logic              halfword_select;
  logic              host_wait_n;
  logic [DATA_W-1:0] hd_host_o;
  logic              hd_host_oe;
  logic [DATA_W-1:0] hd_dev_o;
  logic              hd_dev_oe;
  logic [DATA_W-1:0] host_data_bus;

  // The bus shows whichever end drives; idle it reads as zero.
  assign host_data_bus = hd_dev_oe  ? hd_dev_o :
                         hd_host_oe ? hd_host_o : '0;

  modport host (
    output host_select_n, data_strobe_one_n, data_strobe_two_n,
    output address_latch_strobe_n, access_type_sel, read_not_write,
    output halfword_select, hd_host_o, hd_host_oe,
    input  host_wait_n, host_data_bus
  );

  modport dev (
    input  host_select_n, data_strobe_one_n, data_strobe_two_n,
    input  address_latch_strobe_n, access_type_sel, read_not_write,
    input  halfword_select, host_data_bus,
    output host_wait_n, hd_dev_o, hd_dev_oe
  );
endinterface

// [src/hpp_fifo.sv]
// Purpose: Write buffer between the port and the memory side.
// Assumes: Single clock, valid/ready on both sides.
// Notes:   Flip-flop storage, depth a power of two.
`timescale 1ns/1ps
module hpp_fifo
  import hpp_pkg::*;
#(
  parameter int unsigned WIDTH = FIFO_W,
  parameter int unsigned DEPTH = FIFO_D
) (
  // Clock and reset.
  input  wire logic             sys_clk,
  input  wire logic             rst,
  // Fill side.
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side.
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      rd_q;
  logic             push;
  logic             pop;

  // Full and empty come from pointers that carry one wrap bit.
  assign in_ready  = (wr_q[AW] == rd_q[AW]) || (wr_q[AW-1:0] != rd_q[AW-1:0]);
  assign out_valid = (wr_q != rd_q);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_q[rd_q[AW-1:0]];

  // Pointers advance on each accepted transfer.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop)  rd_q <= rd_q + 1'b1;
    end
  end

  // Storage is written without reset.
  always_ff @(posedge sys_clk) begin
    if (push) mem_q[wr_q[AW-1:0]] <= in_data;
  end
endmodule

// [src/hpp_host_end.sv]
// Purpose: Host end driving the parallel port pins.
// Assumes: Device answers with wait on the same carrier.
// Notes:   One access per command; wait is synchronised.
`timescale 1ns/1ps
module hpp_host_end
  import hpp_pkg::*;
(
  // Clock and reset.
  input  wire logic              sys_clk,
  input  wire logic              rst,
  // Pin side.
  hpp_link_if.host               link,
  // Command port.
  input  wire logic              cmd_valid,
  output logic                   cmd_ready,
  input  wire logic              cmd_read,
  input  wire logic [CTL_W-1:0]  cmd_type,
  input  wire logic              cmd_half,
  input  wire logic              cmd_use_latch,
  input  wire logic [DATA_W-1:0] cmd_wdata,
  output logic                   rsp_valid,
  output logic      [DATA_W-1:0] rsp_rdata
);
  hpp_host_state_t   st_q;
  logic [3:0]        cnt_q;
  logic [2:0]        w_q;
  logic              wait_n;
  logic              rd_q;
  logic              lat_q;
  logic              use_lat_q;
  logic [CTL_W+1:0]  sel_q;
  logic [DATA_W-1:0] wd_q;
  logic [DATA_W-1:0] rd_data_q;
  logic              rsp_q;

  // Wait seen once stages two and three agree low.
  assign wait_n    = w_q[1] | w_q[2];
  assign cmd_ready = (st_q == HS_IDLE);

  // Sequence: latch, strobe low, hold until ready, gap.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_q      <= HS_IDLE;
      cnt_q     <= '0;
      w_q       <= '1;
      rd_q      <= 1'b0;
      lat_q     <= 1'b1;
      use_lat_q <= 1'b0;
      sel_q     <= '0;
      wd_q      <= '0;
      rd_data_q <= '0;
      rsp_q     <= 1'b0;
    end else begin
      w_q   <= {w_q[1:0], link.host_wait_n};
      rsp_q <= 1'b0;
      case (st_q)
        HS_IDLE: if (cmd_valid) begin
          sel_q     <= {cmd_type, cmd_read, cmd_half};
          rd_q      <= cmd_read;
          wd_q      <= cmd_wdata;
          use_lat_q <= cmd_use_latch;
          lat_q     <= !cmd_use_latch;
          st_q      <= HS_LAT;
        end
        HS_LAT: begin
          st_q  <= HS_LOW;
          cnt_q <= HOLD_STB_C;
        end
        HS_LOW: begin
          if (cnt_q != 4'h0) cnt_q <= cnt_q - 4'h1;
          else st_q <= HS_WAIT;
        end
        HS_WAIT: if (!wait_n) begin
          rd_data_q <= link.host_data_bus;
          rsp_q     <= rd_q;
          lat_q     <= 1'b1;
          st_q      <= HS_GAP;
          cnt_q     <= GAP_C;
        end
        HS_GAP: begin
          if (cnt_q != 4'h0) cnt_q <= cnt_q - 4'h1;
          else st_q <= HS_IDLE;
        end
        default: st_q <= HS_IDLE;
      endcase
    end
  end

  // One data strobe low and the other high make the XNOR term zero, so the
  // composite strobe follows the select line alone.
  logic stb_on;
  assign stb_on = (st_q == HS_LOW) || (st_q == HS_WAIT);
  assign link.host_select_n          = !stb_on;
  assign link.data_strobe_one_n      = 1'b0;
  assign link.data_strobe_two_n      = 1'b1;
  assign link.address_latch_strobe_n = lat_q;
  assign {link.access_type_sel, link.read_not_write,
          link.halfword_select} = sel_q;
  assign link.hd_host_o  = wd_q;
  assign link.hd_host_oe = !rd_q && (st_q != HS_IDLE);
  assign rsp_valid = rsp_q;
  assign rsp_rdata = rd_data_q;
endmodule

// [verif/hpp_link_chk.sv]
// Purpose: Assertions on the pin-level link between both ends.
// Assumes: One sys_clk domain, rst asynchronous and active high.
// Notes:   The composite strobe is rebuilt here from its three pins.
`timescale 1ns/1ps
module hpp_link_chk
  import hpp_pkg::*;
(
  // Clock and reset.
  input wire logic             sys_clk,
  input wire logic             rst,
  // Host-driven pins.
  input wire logic             host_select_n,
  input wire logic             data_strobe_one_n,
  input wire logic             data_strobe_two_n,
  input wire logic             address_latch_strobe_n,
  input wire logic [CTL_W-1:0] access_type_sel,
  input wire logic             read_not_write,
  input wire logic             halfword_select,
  // Device-driven pins.
  input wire logic             host_wait_n,
  input wire logic             hd_dev_oe
);
  // --------------------------------------------------------------------
  // Composite strobe and access starts.
  // --------------------------------------------------------------------
  // Low while an access is active.
  wire stb_n;
  assign stb_n = ~(data_strobe_one_n ^ data_strobe_two_n) | host_select_n;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // A data read that must fetch, and a second half served from the fetch.
  sequence rd_fetch_s;
    $fell(stb_n) && read_not_write && access_type_sel[1] && !halfword_select;
  endsequence
  sequence rd_second_s;
    $fell(stb_n) && read_not_write && access_type_sel[1] && halfword_select;
  endsequence

  // --------------------------------------------------------------------
  // Assertions.
  // --------------------------------------------------------------------
  wait_fetch_a: assert property (
    rd_fetch_s |-> ##[1:8] host_wait_n) else $error("no wait on fetch read");
  second_half_a: assert property (
    rd_second_s |-> !host_wait_n [*6]) else $error("wait on second half");
  hold_stb_a: assert property (
    (!stb_n && host_wait_n) |=> !stb_n) else $error("strobe left early");
  strobe_gap_a: assert property (
    $rose(stb_n) |-> stb_n [*4]) else $error("strobe gap too short");
  latch_once_a: assert property (
    (!stb_n && !$past(stb_n)) |-> !$fell(address_latch_strobe_n))
    else $error("second latch pulse");
  latch_lead_a: assert property (
    ($fell(stb_n) && !address_latch_strobe_n) |->
    !$past(address_latch_strobe_n))
    else $error("latch after strobe");
  sel_hold_a: assert property (
    (!stb_n && !$past(stb_n)) |-> $stable(access_type_sel) &&
    $stable(read_not_write) && $stable(halfword_select))
    else $error("selects moved");
  oe_on_a: assert property (
    $rose(hd_dev_oe) |-> !stb_n && read_not_write) else $error("early drive");
  oe_off_a: assert property (
    $rose(stb_n) |-> ##[0:6] !hd_dev_oe) else $error("bus not released");
endmodule

// [verif/tb.sv]
// Purpose: Self-checking bench joining host end and device end.
// Assumes: 200 MHz sys_clk, inputs driven at the falling edge.
// Notes:   Fetch responder and drain are bench models; the drain checks against a queue.
`timescale 1ns/1ps
module tb;
  import hpp_pkg::*;
  // --------------------------------------------------------------------
  // Signals and bench state.
  // --------------------------------------------------------------------
  logic              sys_clk, rst, narrow_16bit_mode, hold;
  logic              fetch_req, fetch_ack, wr_valid, wr_ready;
  logic [CTL_W-1:0]  fetch_type, ctl_type, cmd_type, cur_ty;
  logic [DATA_W-1:0] fetch_data, wr_data, cmd_wdata, rsp_rdata, last_f;
  logic              cmd_valid, cmd_ready, cmd_read, cmd_half;
  logic              cmd_use_latch, rsp_valid;
  int                checks, mismatches, nfetch, fdly, i, n;
  integer            seed;
  logic [DATA_W-1:0] wq[$];

  hpp_link_if link ();
  hpp_host_end u_hpp_host_end (.sys_clk(sys_clk), .rst(rst), .link(link),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_read(cmd_read),
    .cmd_type(cmd_type), .cmd_half(cmd_half), .cmd_use_latch(cmd_use_latch),
    .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));
  hpp_dev_end u_hpp_dev_end (.sys_clk(sys_clk), .rst(rst), .link(link),
    .narrow_16bit_mode(narrow_16bit_mode), .fetch_req(fetch_req),
    .fetch_type(fetch_type), .fetch_ack(fetch_ack), .fetch_data(fetch_data),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data),
    .ctl_type(ctl_type));
  hpp_link_chk u_chk (.sys_clk(sys_clk), .rst(rst),
    .host_select_n(link.host_select_n),
    .data_strobe_one_n(link.data_strobe_one_n),
    .data_strobe_two_n(link.data_strobe_two_n),
    .address_latch_strobe_n(link.address_latch_strobe_n),
    .access_type_sel(link.access_type_sel),
    .read_not_write(link.read_not_write),
    .halfword_select(link.halfword_select),
    .host_wait_n(link.host_wait_n), .hd_dev_oe(link.hd_dev_oe));

  // Free-running clock.
  initial begin
    sys_clk = 1'h0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // --------------------------------------------------------------------
  // Checking and closing.
  // --------------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task summarize;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Bounded wait on falling edges; a used-up bound ends the run.
  task automatic await(input int lim);
    if (n >= lim) begin
      mismatches++;
      $display("[ERR] %0t wait bound used up", $time);
      summarize();
    end
  endtask

  // Fetch responder: answers after a random delay, records the word.
  always @(negedge sys_clk) begin
    if (fetch_ack) begin
      fetch_ack = 1'h0;
    end else if (fetch_req === 1'h1) begin
      if (fdly > 0) begin
        fdly--;
      end else begin
        chk(32'(fetch_type), 32'(cur_ty));
        fetch_data = $random(seed);
        last_f     = fetch_data;
        fetch_ack  = 1'h1;
        nfetch++;
        fdly       = $random(seed) & 7;
      end
    end
  end

  // Drain side stalls at random unless held; words leave in order.
  always @(negedge sys_clk) if (!hold) wr_ready = 1'($random(seed));
  always @(posedge sys_clk) begin
    if (!rst && wr_valid && wr_ready) begin
      if (wq.size() == 0) chk(wr_data, 32'hFFFF_FFFF);
      else chk(wr_data, wq.pop_front());
    end
  end

  // --------------------------------------------------------------------
  // Access tasks, entered just after a falling edge.
  // --------------------------------------------------------------------
  task automatic acc(input logic rd, input logic [1:0] ty, input logic hf,
                     input logic [31:0] wd);
    cmd_valid = 1'h1;
    cmd_read = rd;
    cmd_type = ty;
    cmd_half = hf;
    cur_ty = ty;
    cmd_use_latch = 1'($random(seed));
    cmd_wdata = wd;
    for (n = 0; n < 400 && cmd_ready !== 1'h1; n++) @(negedge sys_clk);
    await(400);
    @(negedge sys_clk);
    cmd_valid = 1'h0;
    if (rd) begin
      for (n = 0; n < 400 && rsp_valid !== 1'h1; n++) @(negedge sys_clk);
      await(400);
    end
  endtask

  task automatic rd_word(input logic [1:0] ty);
    int nf;
    nf = nfetch;
    acc(1'h1, ty, 1'h0, 32'h0);
    chk(32'(nfetch), 32'(nf + 1));
    if (!narrow_16bit_mode) begin
      chk(rsp_rdata, last_f);
    end else begin
      chk(32'(rsp_rdata[15:0]), 32'(last_f[15:0]));
      nf = nfetch;
      acc(1'h1, ty, 1'h1, 32'h0);
      chk(32'(nfetch), 32'(nf));
      chk(32'(rsp_rdata[15:0]), 32'(last_f[31:16]));
    end
  endtask

  task automatic wr_word(input logic [1:0] ty, input logic [31:0] w);
    if (ty[1]) wq.push_back(w);
    if (!narrow_16bit_mode) begin
      acc(1'h0, ty, 1'h0, w);
    end else begin
      acc(1'h0, ty, 1'h0, {16'h0, w[15:0]});
      acc(1'h0, ty, 1'h1, {16'h0, w[31:16]});
    end
  endtask

  // Waits until the host end is idle again.
  task automatic idle;
    for (n = 0; n < 400 && cmd_ready !== 1'h1; n++) @(negedge sys_clk);
    await(400);
  endtask

  // --------------------------------------------------------------------
  // Main sequence.
  // --------------------------------------------------------------------
  initial begin
    seed = 32'h296c;
    {rst, hold, narrow_16bit_mode, fetch_ack, wr_ready} = 5'h10;
    {cmd_valid, cmd_read, cmd_half, cmd_use_latch} = 4'h0;
    {cmd_type, cur_ty, cmd_wdata, fetch_data} = '0;
    {checks, mismatches, nfetch, fdly} = '0;
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    rst = 1'h0;
    for (i = 0; i < 6; i++) rd_word(i[0] ? ACC_DATA : ACC_DINC);
    // A control-type read is served without a fetch.
    i = nfetch;
    acc(1'h1, ACC_CTRL, 1'h0, 32'h0);
    chk(32'(nfetch), 32'(i));
    $display("test wide_read done");
    for (i = 0; i < 8; i++) wr_word(2'(i), $random(seed));
    idle();
    chk(32'(ctl_type), 32'(cur_ty));
    $display("test wide_write done");
    narrow_16bit_mode = 1'h1;
    for (i = 0; i < 4; i++) begin
      rd_word(i[0] ? ACC_DATA : ACC_DINC);
      wr_word(ACC_DATA, $random(seed));
    end
    idle();
    $display("test narrow done");
    narrow_16bit_mode = 1'h0;
    // Start the fill from an empty buffer so only the last write stalls.
    for (n = 0; n < 400 && wq.size() != 0; n++) @(negedge sys_clk);
    await(400);
    hold = 1'h1;
    wr_ready = 1'h0;
    for (i = 0; i <= FIFO_D; i++) wr_word(ACC_DATA, $random(seed));
    repeat (30) @(negedge sys_clk);
    chk(32'(link.host_wait_n), 32'h1);
    hold = 1'h0;
    for (n = 0; n < 2000 && wq.size() != 0; n++) @(negedge sys_clk);
    await(2000);
    idle();
    chk(32'(wq.size()), 32'h0);
    $display("test fill_drain done");
    summarize();
  end
endmodule
